// file: logic/lpdc_pkg.sv
// Contract
// - backlight input enables backlight group, pulses pick one of 11 levels
// - first backlight high from shutdown: soft-start, then full scale
// - each later backlight pulse drops 10 percent; the tenth drops 5
// - pulse after lowest backlight level wraps to full scale
// - first flash high: soft-start unless already done, then 100 mA
// - flash pulses drop 10 mA, tenth drops 5 mA, next returns full
// - flash adjust pulses accepted within 1 ms of flash going high; code accepts them at any time
// - backlight low 0.5 ms: sinks off, full scale on next rise
// - flash low 0.5 ms: flash level back to 100 mA on next rise
// - both inputs low 0.5 ms: full shutdown
// - ratio 1x while all sinks above threshold; 1.5x if any below
// - going 1x toward 2x dwells about 1 ms at 1.5x
// - at 1.5x with output below input, retry 1x every 130 ms
// - at 2x, fall back to 1.5x every 130 ms, re-enter if needed
// - step 1.5x to 2x only on sink dropout
// - at 2x, one input long low with other high: back to 1.5x
// - output below 1.2 V: short state, resume when removed
// - sink disabled when its pin exceeds output or input minus 0.4 V
// - over 165 C shut down, restart automatically after cooling
// - open LED: other sinks keep running, resume when fault clears
package lpdc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned T_RESET_NS    = 500_000;
   localparam int unsigned T_DWELL_NS    = 1_000_000;
   localparam int unsigned T_RETRY_NS    = 130_000_000;
   localparam int unsigned T_SOFT_NS     = 2_000_000;
   localparam int unsigned RESET_CYC =
      (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned DWELL_CYC = T_DWELL_NS / CLK_PERIOD_NS;
   localparam int unsigned RETRY_CYC = T_RETRY_NS / CLK_PERIOD_NS;
   localparam int unsigned SOFT_CYC  = T_SOFT_NS / CLK_PERIOD_NS;

   localparam int unsigned LOW_W = 16;
   localparam int unsigned TMR_W = 24;
   localparam int unsigned PCT_W = 7;
   localparam logic [3:0]  LVL_FULL = 4'h0;
   localparam logic [3:0]  LVL_LAST = 4'ha;
   localparam logic [6:0]  PCT_FULL = 7'h64;
   localparam logic [6:0]  PCT_STEP = 7'h0a;
   localparam logic [6:0]  PCT_LAST = 7'h05;

   // positions in the synchronised input vector
   localparam int unsigned SX_BL    = 0;
   localparam int unsigned SX_FL    = 1;
   localparam int unsigned SX_SLO   = 2;
   localparam int unsigned SX_DROP  = 8;
   localparam int unsigned SX_VLT   = 9;
   localparam int unsigned SX_SHORT = 10;
   localparam int unsigned SX_OVR   = 11;
   localparam int unsigned SX_OT    = 17;
   localparam int unsigned SX_W     = 18;
   localparam int unsigned N_SINK   = 6;

   typedef enum logic [1:0] {
      SYS_SHDN = 2'h0,
      SYS_SOFT = 2'h1,
      SYS_RUN  = 2'h3,
      SYS_HOT  = 2'h2
   } lpdc_sys_t;

   typedef enum logic [1:0] {
      RATIO_1X  = 2'h0,
      RATIO_15X = 2'h1,
      RATIO_2X  = 2'h3
   } lpdc_ratio_t;

   typedef struct packed {
      logic             en;
      logic             low_long;
      logic             rise;
      logic [3:0]       idx;
      logic [PCT_W-1:0] pct;
   } lpdc_chan_t;

   function automatic logic [PCT_W-1:0] lvl_pct(input logic [3:0] idx);
      if (idx >= LVL_LAST)
         return PCT_LAST;
      return PCT_FULL - PCT_W'(PCT_STEP * PCT_W'(idx));
   endfunction
endpackage

// file: logic/lpdc_sync.sv
`timescale 1ns/1ps
module lpdc_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule

// file: logic/lpdc_dim_chan.sv
`timescale 1ns/1ps
module lpdc_dim_chan #(
   parameter int unsigned RESET_CYC = lpdc_pkg::RESET_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic              ctl_i,
   output lpdc_pkg::lpdc_chan_t   st_o
);
   localparam logic [lpdc_pkg::LOW_W-1:0] LIM =
      lpdc_pkg::LOW_W'(RESET_CYC - 1);

   logic                           prev_ff, nxt_prev;
   logic                           en_ff, nxt_en;
   logic                           ll_ff, nxt_ll;
   logic [lpdc_pkg::LOW_W-1:0]     cnt_ff, nxt_cnt;
   logic [3:0]                     idx_ff, nxt_idx;
   logic [lpdc_pkg::PCT_W-1:0]     pct_ff, nxt_pct;
   logic                           rise;

   always_comb begin
      rise     = ctl_i & ~prev_ff;
      nxt_prev = ctl_i;
      nxt_en   = en_ff;
      nxt_ll   = ll_ff;
      nxt_cnt  = cnt_ff;
      nxt_idx  = idx_ff;
      if (ctl_i) begin
         nxt_cnt = '0;
         nxt_ll  = 1'b0;
      end else if (cnt_ff != LIM) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else begin
         // long low: off now, full scale waits for the next rise
         nxt_ll = 1'b1;
         nxt_en = 1'b0;
      end
      // pulses count from the first rise, soft-start or not
      if (rise) begin
         if (!en_ff) begin
            nxt_en  = 1'b1;
            nxt_idx = lpdc_pkg::LVL_FULL;
         end else if (idx_ff == lpdc_pkg::LVL_LAST) begin
            nxt_idx = lpdc_pkg::LVL_FULL;
         end else begin
            nxt_idx = idx_ff + 4'h1;
         end
      end
      nxt_pct = lpdc_pkg::lvl_pct(nxt_idx);
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_ff <= 1'b0;
         en_ff   <= 1'b0;
         ll_ff   <= 1'b0;
         cnt_ff  <= '0;
         idx_ff  <= 4'h0;
         pct_ff  <= lpdc_pkg::PCT_FULL;
      end else begin
         prev_ff <= nxt_prev;
         en_ff   <= nxt_en;
         ll_ff   <= nxt_ll;
         cnt_ff  <= nxt_cnt;
         idx_ff  <= nxt_idx;
         pct_ff  <= nxt_pct;
      end
   end

   // one driver for the whole struct, members in declared order
   assign st_o = {en_ff, ll_ff, rise, idx_ff, pct_ff};

   chk_step_level: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      rise && en_ff && idx_ff != lpdc_pkg::LVL_LAST
      |=> idx_ff == $past(idx_ff) + 4'h1)
      else $error("level did not step down");

   chk_wrap_level: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      rise && en_ff && idx_ff == lpdc_pkg::LVL_LAST
      |=> idx_ff == lpdc_pkg::LVL_FULL && pct_ff == lpdc_pkg::PCT_FULL)
      else $error("level did not wrap to full");

   chk_first_full: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      rise && !en_ff |=> en_ff && pct_ff == lpdc_pkg::PCT_FULL)
      else $error("first rise not full scale");

   chk_low_reset: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      $rose(ll_ff) |-> !en_ff && !$past(ctl_i))
      else $error("long low did not disable channel");
endmodule

// file: logic/lpdc_top.sv
`timescale 1ns/1ps
module lpdc_top #(
   parameter int unsigned RESET_CYC = lpdc_pkg::RESET_CYC,
   parameter int unsigned DWELL_CYC = lpdc_pkg::DWELL_CYC,
   parameter int unsigned RETRY_CYC = lpdc_pkg::RETRY_CYC,
   parameter int unsigned SOFT_CYC  = lpdc_pkg::SOFT_CYC
) (
   input  wire logic                          ref_clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          backlight_ctrl_in_i,
   input  wire logic                          flash_ctrl_in_i,
   input  wire logic [lpdc_pkg::N_SINK-1:0]   sink_low_i,
   input  wire logic                          sink_dropout_i,
   input  wire logic                          pump_output_voltage_below_vin_i,
   input  wire logic                          pump_output_voltage_short_i,
   input  wire logic [lpdc_pkg::N_SINK-1:0]   sink_over_i,
   input  wire logic                          over_temp_i,
   output logic      [lpdc_pkg::N_SINK-1:0]   sink_channel_en_o,
   output logic      [lpdc_pkg::PCT_W-1:0]    backlight_pct_o,
   output logic      [lpdc_pkg::PCT_W-1:0]    flash_pct_o,
   output logic      [1:0]                    pump_ratio_o,
   output logic                               soft_start_o,
   output logic                               shutdown_o,
   output logic                               short_state_o
);
   localparam int unsigned TW = lpdc_pkg::TMR_W;
   localparam logic [TW-1:0] SOFT_LIM  = TW'(SOFT_CYC - 1);
   localparam logic [TW-1:0] DWELL_LIM = TW'(DWELL_CYC - 1);
   localparam logic [TW-1:0] RETRY_LIM = TW'(RETRY_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   logic [lpdc_pkg::SX_W-1:0]   sx;
   lpdc_pkg::lpdc_chan_t        bl_st;
   lpdc_pkg::lpdc_chan_t        fl_st;

   lpdc_sync #(
      .W (lpdc_pkg::SX_W)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .d_i       ({over_temp_i, sink_over_i, pump_output_voltage_short_i,
                   pump_output_voltage_below_vin_i, sink_dropout_i, sink_low_i,
                   flash_ctrl_in_i, backlight_ctrl_in_i}),
      .q_o       (sx)
   );

   lpdc_dim_chan #(
      .RESET_CYC (RESET_CYC)
   ) u_bl (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .ctl_i     (sx[lpdc_pkg::SX_BL]),
      .st_o      (bl_st)
   );

   lpdc_dim_chan #(
      .RESET_CYC (RESET_CYC)
   ) u_fl (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .ctl_i     (sx[lpdc_pkg::SX_FL]),
      .st_o      (fl_st)
   );

   logic                          bl_hi, fl_hi;
   logic [lpdc_pkg::N_SINK-1:0]   low_s, over_s;
   logic                          drop_s, vlt_s, short_s, ot_s;

   assign bl_hi   = sx[lpdc_pkg::SX_BL];
   assign fl_hi   = sx[lpdc_pkg::SX_FL];
   assign low_s   = sx[lpdc_pkg::SX_SLO +: lpdc_pkg::N_SINK];
   assign over_s  = sx[lpdc_pkg::SX_OVR +: lpdc_pkg::N_SINK];
   assign drop_s  = sx[lpdc_pkg::SX_DROP];
   assign vlt_s   = sx[lpdc_pkg::SX_VLT];
   assign short_s = sx[lpdc_pkg::SX_SHORT];
   assign ot_s    = sx[lpdc_pkg::SX_OT];

   ////////////////////////////////////////////////////////////////////////
   // system sequencing: shutdown, soft-start, run, thermal hold
   lpdc_pkg::lpdc_sys_t  sys_ff, nxt_sys;
   logic [TW-1:0]        ss_ff, nxt_ss;
   logic                 both_low;

   always_comb begin
      nxt_sys  = sys_ff;
      nxt_ss   = ss_ff;
      both_low = bl_st.low_long & fl_st.low_long;
      case (sys_ff)
         lpdc_pkg::SYS_SHDN: begin
            nxt_ss = '0;
            if (ot_s)
               nxt_sys = lpdc_pkg::SYS_HOT;
            else if (bl_st.en | fl_st.en)
               nxt_sys = lpdc_pkg::SYS_SOFT;
         end
         lpdc_pkg::SYS_SOFT: begin
            if (ot_s)
               nxt_sys = lpdc_pkg::SYS_HOT;
            else if (both_low)
               nxt_sys = lpdc_pkg::SYS_SHDN;
            else if (ss_ff == SOFT_LIM)
               nxt_sys = lpdc_pkg::SYS_RUN;
            else
               nxt_ss = ss_ff + 1'b1;
         end
         lpdc_pkg::SYS_RUN: begin
            // a later flash enable joins without a second soft-start
            if (ot_s)
               nxt_sys = lpdc_pkg::SYS_HOT;
            else if (both_low)
               nxt_sys = lpdc_pkg::SYS_SHDN;
            else
               nxt_sys = lpdc_pkg::SYS_RUN;
         end
         lpdc_pkg::SYS_HOT: begin
            // cooled down: restart through soft-start if still enabled
            if (!ot_s)
               nxt_sys = lpdc_pkg::SYS_SHDN;
         end
         default: nxt_sys = lpdc_pkg::SYS_SHDN;
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sys_ff <= lpdc_pkg::SYS_SHDN;
         ss_ff  <= '0;
      end else begin
         sys_ff <= nxt_sys;
         ss_ff  <= nxt_ss;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // charge-pump ratio; one timer serves dwell and periodic retry
   lpdc_pkg::lpdc_ratio_t  ratio_ff, nxt_ratio;
   logic [TW-1:0]          tmr_ff, nxt_tmr;
   logic [1:0]             ll_prev_ff, nxt_ll_prev;
   logic                   run, chan_dis;

   always_comb begin
      nxt_ratio   = ratio_ff;
      nxt_tmr     = (tmr_ff == RETRY_LIM) ? tmr_ff : tmr_ff + 1'b1;
      nxt_ll_prev = {fl_st.low_long, bl_st.low_long};
      run         = (sys_ff == lpdc_pkg::SYS_RUN) & ~short_s;
      chan_dis    = (bl_st.low_long & ~ll_prev_ff[0] & fl_hi) |
                    (fl_st.low_long & ~ll_prev_ff[1] & bl_hi);
      if (!run) begin
         nxt_ratio = lpdc_pkg::RATIO_1X;
         nxt_tmr   = '0;
      end else begin
         case (ratio_ff)
            lpdc_pkg::RATIO_1X: begin
               if (|low_s) begin
                  nxt_ratio = lpdc_pkg::RATIO_15X;
                  nxt_tmr   = '0;
               end
            end
            lpdc_pkg::RATIO_15X: begin
               if (drop_s && tmr_ff >= DWELL_LIM) begin
                  nxt_ratio = lpdc_pkg::RATIO_2X;
                  nxt_tmr   = '0;
               end else if (vlt_s && tmr_ff == RETRY_LIM) begin
                  nxt_ratio = lpdc_pkg::RATIO_1X;
                  nxt_tmr   = '0;
               end
            end
            lpdc_pkg::RATIO_2X: begin
               if (chan_dis || tmr_ff == RETRY_LIM) begin
                  nxt_ratio = lpdc_pkg::RATIO_15X;
                  nxt_tmr   = '0;
               end
            end
            default: begin
               nxt_ratio = lpdc_pkg::RATIO_1X;
               nxt_tmr   = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ratio_ff   <= lpdc_pkg::RATIO_1X;
         tmr_ff     <= '0;
         ll_prev_ff <= 2'h0;
      end else begin
         ratio_ff   <= nxt_ratio;
         tmr_ff     <= nxt_tmr;
         ll_prev_ff <= nxt_ll_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sink enables: per-pin disable keeps a faulty sink from stopping others
   logic [lpdc_pkg::N_SINK-1:0]  sink_ff, nxt_sink;
   logic                         short_ff, nxt_short;

   always_comb begin
      nxt_sink = {{2{run & fl_st.en}}, {4{run & bl_st.en}}};
      nxt_sink = nxt_sink & ~over_s;
      nxt_short = short_s & (sys_ff == lpdc_pkg::SYS_RUN);
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sink_ff  <= '0;
         short_ff <= 1'b0;
      end else begin
         sink_ff  <= nxt_sink;
         short_ff <= nxt_short;
      end
   end

   assign sink_channel_en_o = sink_ff;
   assign backlight_pct_o   = bl_st.pct;
   assign flash_pct_o       = fl_st.pct;
   assign pump_ratio_o      = ratio_ff;
   assign soft_start_o      = (sys_ff == lpdc_pkg::SYS_SOFT);
   assign shutdown_o        = (sys_ff == lpdc_pkg::SYS_SHDN) |
                              (sys_ff == lpdc_pkg::SYS_HOT);
   assign short_state_o     = short_ff;

   ////////////////////////////////////////////////////////////////////////
   chk_shut_both: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      both_low && !ot_s && sys_ff != lpdc_pkg::SYS_HOT
      |=> sys_ff == lpdc_pkg::SYS_SHDN)
      else $error("both inputs long low but not shut down");

   chk_ratio_up: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      run && ratio_ff == lpdc_pkg::RATIO_1X && |low_s
      |=> ratio_ff == lpdc_pkg::RATIO_15X)
      else $error("sink low at 1x did not raise ratio");

   chk_ratio_dwell: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      ratio_ff == lpdc_pkg::RATIO_2X &&
      $past(ratio_ff) == lpdc_pkg::RATIO_15X
      |-> $past(tmr_ff) >= DWELL_LIM && $past(drop_s))
      else $error("2x entered without dwell or dropout");

   chk_retry_2x: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      run && ratio_ff == lpdc_pkg::RATIO_2X && tmr_ff == RETRY_LIM
      |=> ratio_ff == lpdc_pkg::RATIO_15X && tmr_ff == '0)
      else $error("2x retry period missed");

   chk_retry_1x: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      run && ratio_ff == lpdc_pkg::RATIO_15X && vlt_s && !drop_s &&
      tmr_ff == RETRY_LIM |=> ratio_ff == lpdc_pkg::RATIO_1X)
      else $error("1.5x retry to 1x missed");

   chk_chan_drop: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      run && ratio_ff == lpdc_pkg::RATIO_2X && chan_dis
      |=> ratio_ff == lpdc_pkg::RATIO_15X)
      else $error("channel disable at 2x kept 2x");

   chk_short_off: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      short_s |=> sink_ff == '0 && ratio_ff == lpdc_pkg::RATIO_1X)
      else $error("sinks or pump active during short");

   chk_sink_disable: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      1'b1 |=> (sink_ff & $past(over_s)) == '0)
      else $error("overvoltage sink still enabled");

   chk_over_temp: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      ot_s |=> sys_ff == lpdc_pkg::SYS_HOT ##1 sink_ff == '0)
      else $error("over temperature did not shut down");

   chk_soft_done: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      sys_ff == lpdc_pkg::SYS_SOFT && ss_ff == SOFT_LIM &&
      !ot_s && !both_low |=> sys_ff == lpdc_pkg::SYS_RUN)
      else $error("soft-start did not end in run");

   chk_bl_group: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      !bl_st.en |=> sink_ff[3:0] == 4'h0)
      else $error("backlight sinks on while group disabled");

   chk_fl_group: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      !fl_st.en |=> sink_ff[5:4] == 2'h0)
      else $error("flash sinks on while group disabled");

   chk_hot_hold: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      sys_ff == lpdc_pkg::SYS_HOT && ot_s |=> sys_ff == lpdc_pkg::SYS_HOT)
      else $error("left thermal hold while still hot");

   chk_no_dropout_step: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      ratio_ff == lpdc_pkg::RATIO_15X && !drop_s
      |=> ratio_ff != lpdc_pkg::RATIO_2X)
      else $error("2x entered without dropout");

   chk_idle_ratio: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      !run |=> ratio_ff == lpdc_pkg::RATIO_1X)
      else $error("pump not at 1x while stopped");
endmodule

// file: test/lpdc_host_model.sv
`timescale 1ns/1ps
module lpdc_host_model #(
   parameter int unsigned RESET_CYC = 20
) (
   input  wire logic ref_clk_i,
   output logic      backlight_ctrl_in_o,
   output logic      flash_ctrl_in_o
);
   logic [1:0] line_lvl;

   assign backlight_ctrl_in_o = line_lvl[0];
   assign flash_ctrl_in_o     = line_lvl[1];

   initial line_lvl = 2'h0;

   // push-pull lines, so the last driven level is the real wire level
   task automatic drive(input int ch, input logic v);
      @(negedge ref_clk_i);
      line_lvl[ch] = v;
   endtask

   // 6 cycles a pulse keeps a whole burst far inside the flicker limit
   task automatic pulses(input int ch, input int n);
      repeat (n) begin
         drive(ch, 1'b0);
         repeat (2) @(negedge ref_clk_i);
         drive(ch, 1'b1);
         repeat (2) @(negedge ref_clk_i);
      end
   endtask

   task automatic long_low(input int ch);
      drive(ch, 1'b0);
      repeat (RESET_CYC + 8) @(negedge ref_clk_i);
   endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int RST = 20;
   localparam int DW  = 40;
   localparam int RT  = 200;
   localparam int SS  = 50;

   logic       ref_clk_i   = 1'b0;
   logic       reset_i     = 1'b1;
   logic [5:0] sink_low_i  = 6'h00;
   logic [5:0] sink_over_i = 6'h00;
   logic       dropout     = 1'b0;
   logic       vbelow      = 1'b0;
   logic       vshort      = 1'b0;
   logic       hot         = 1'b0;
   logic       bl;
   logic       fl;
   logic [5:0] sink_en;
   logic [6:0] bl_pct;
   logic [6:0] fl_pct;
   logic [1:0] ratio;
   logic       ss;
   logic       sd;
   logic       sh;
   int         mismatches = 0;
   int         compares   = 0;
   int         seed       = 41194;
   int         bn         = 0;
   int         n;
   int         c;
   logic [5:0] ov;

   initial forever #12.5 ref_clk_i = ~ref_clk_i;

   lpdc_host_model #(.RESET_CYC(RST)) host (
      .ref_clk_i           (ref_clk_i),
      .backlight_ctrl_in_o (bl),
      .flash_ctrl_in_o     (fl)
   );

   lpdc_top #(.RESET_CYC(RST), .DWELL_CYC(DW), .RETRY_CYC(RT),
              .SOFT_CYC(SS)) i_dut (
      .ref_clk_i           (ref_clk_i),
      .reset_i             (reset_i),
      .backlight_ctrl_in_i (bl),
      .flash_ctrl_in_i     (fl),
      .sink_low_i          (sink_low_i),
      .sink_dropout_i      (dropout),
      .pump_output_voltage_below_vin_i    (vbelow),
      .pump_output_voltage_short_i        (vshort),
      .sink_over_i         (sink_over_i),
      .over_temp_i         (hot),
      .sink_channel_en_o   (sink_en),
      .backlight_pct_o     (bl_pct),
      .flash_pct_o         (fl_pct),
      .pump_ratio_o        (ratio),
      .soft_start_o        (ss),
      .shutdown_o          (sd),
      .short_state_o       (sh)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      chk_val({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wait_ratio(input logic [1:0] v, input int mx);
      c = 0;
      while (ratio !== v && c < mx) begin
         cyc(1);
         c++;
      end
      chk_val(8'(ratio), 8'(v));
   endtask

   function automatic logic [7:0] exp_pct(input int k);
      return (k % 11 == 10) ? 8'h05 : 8'(100 - 10 * (k % 11));
   endfunction

   task automatic final_report();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      mismatches++;
      final_report();
   end

   initial begin
      cyc(6);
      reset_i = 1'b0;
      cyc(2);
      chk_flag(sd, 1'b1);
      chk_val(8'(bl_pct), 8'h64);
      chk_val(8'(sink_en), 8'h00);
      host.drive(0, 1'b1);
      cyc(8);
      chk_flag(ss, 1'b1);
      chk_flag(sd, 1'b0);
      cyc(SS + 8);
      chk_val(8'(sink_en), 8'h0f);
      chk_val(8'(bl_pct), 8'h64);
      $display("test power_up done");
      for (int k = 1; k <= 11; k++) begin
         host.pulses(0, 1);
         cyc(6);
         chk_val(8'(bl_pct), exp_pct(k));
      end
      repeat (3) begin
         n = {$random(seed)} % 11;
         host.pulses(0, n);
         bn = (bn + n) % 11;
         cyc(6);
         chk_val(8'(bl_pct), exp_pct(bn));
      end
      $display("test dimming done");
      host.drive(1, 1'b1);
      cyc(6);
      chk_flag(ss, 1'b0);
      chk_val(8'(fl_pct), 8'h64);
      chk_val(8'(sink_en), 8'h3f);
      host.pulses(1, 10);
      cyc(6);
      chk_val(8'(fl_pct), 8'h05);
      host.pulses(1, 1);
      cyc(6);
      chk_val(8'(fl_pct), 8'h64);
      ov = 6'h01 << ({$random(seed)} % 6);
      sink_over_i = ov;
      cyc(6);
      chk_val(8'(sink_en), 8'(6'h3f & ~ov));
      sink_over_i = 6'h00;
      cyc(6);
      chk_val(8'(sink_en), 8'h3f);
      $display("test flash_and_sinks done");
      sink_low_i = 6'h01;
      dropout = 1'b1;
      cyc(6);
      chk_val(8'(ratio), 8'h01);
      wait_ratio(2'h3, DW + 10);
      chk_flag(c >= DW - 8, 1'b1);
      wait_ratio(2'h1, RT + 10);
      chk_flag(c >= RT - 10, 1'b1);
      dropout = 1'b0;
      vbelow = 1'b1;
      wait_ratio(2'h0, RT + 10);
      chk_flag(c >= RT - 10, 1'b1);
      cyc(6);
      chk_val(8'(ratio), 8'h01);
      vbelow = 1'b0;
      dropout = 1'b1;
      wait_ratio(2'h3, DW + 20);
      host.pulses(0, 2);
      host.long_low(0);
      chk_val(8'(ratio), 8'h01);
      chk_val(8'(sink_en), 8'h30);
      dropout = 1'b0;
      sink_low_i = 6'h00;
      host.drive(0, 1'b1);
      cyc(6);
      chk_val(8'(bl_pct), 8'h64);
      $display("test pump done");
      host.pulses(1, 3);
      host.long_low(1);
      host.drive(1, 1'b1);
      cyc(6);
      chk_val(8'(fl_pct), 8'h64);
      host.long_low(0);
      host.drive(0, 1'b1);
      host.pulses(0, 7);
      cyc(6);
      chk_val(8'(bl_pct), 8'h1e);
      vshort = 1'b1;
      cyc(6);
      chk_flag(sh, 1'b1);
      chk_val(8'(sink_en), 8'h00);
      vshort = 1'b0;
      cyc(6);
      chk_flag(sh, 1'b0);
      chk_val(8'(sink_en), 8'h3f);
      hot = 1'b1;
      cyc(6);
      chk_flag(sd, 1'b1);
      chk_val(8'(sink_en), 8'h00);
      hot = 1'b0;
      cyc(SS + 16);
      chk_val(8'(sink_en), 8'h3f);
      $display("test faults done");
      host.drive(0, 1'b0);
      host.drive(1, 1'b0);
      cyc(RST + 8);
      chk_flag(sd, 1'b1);
      chk_val(8'(sink_en), 8'h00);
      host.drive(1, 1'b1);
      cyc(4);
      host.pulses(1, 3);
      chk_flag(ss, 1'b1);
      cyc(SS + 8);
      chk_val(8'(fl_pct), 8'h46);
      chk_val(8'(sink_en), 8'h30);
      $display("test shutdown done");
      final_report();
   end
endmodule
